/* File: hw/ocp_pkg.sv */
package ocp_pkg;

  // -------------------------------------------------------------
  // timing
  // -------------------------------------------------------------
  localparam int unsigned CLK_HZ      = 25_000_000;
  localparam int unsigned RF_FAST_MS  = 10;
  localparam int unsigned RF_STD_MS   = 100;
  localparam int unsigned RF_SLOW_MS  = 1000;
  localparam int unsigned STAG_MS     = 50;
  localparam int unsigned RF_FAST_CYC = CLK_HZ / 1000 * RF_FAST_MS;
  localparam int unsigned RF_STD_CYC  = CLK_HZ / 1000 * RF_STD_MS;
  localparam int unsigned RF_SLOW_CYC = CLK_HZ / 1000 * RF_SLOW_MS;
  localparam int unsigned STAG_CYC    = CLK_HZ / 1000 * STAG_MS;
  localparam int unsigned CNT_W       = 25;
  localparam int unsigned TAB_N       = 26;
  localparam logic [4:0]  TAB_LAST    = 5'h19;

  // -------------------------------------------------------------
  // object indices and subindices
  // -------------------------------------------------------------
  localparam logic [15:0] IDX_RST   = 16'h1011;
  localparam logic [15:0] IDX_SET   = 16'h8000;
  localparam logic [15:0] IDX_TAB   = 16'h8001;
  localparam logic [15:0] IDX_STEP  = 16'h0010;
  localparam logic [7:0]  SUB_CNT   = 8'h00;
  localparam logic [7:0]  SUB_KEY   = 8'h01;
  localparam logic [7:0]  SUB_RATED = 8'h11;
  localparam logic [7:0]  SUB_CURVE = 8'h12;
  localparam logic [7:0]  SUB_WARN  = 8'h13;
  localparam logic [7:0]  SUB_PRET  = 8'h14;
  localparam logic [7:0]  SUB_INFN  = 8'h15;
  localparam logic [7:0]  SUB_OVR   = 8'h16;
  localparam logic [7:0]  SUB_UVL   = 8'h17;
  localparam logic [7:0]  SUB_RFF   = 8'h18;
  localparam logic [7:0]  SUB_LOCK  = 8'h19;
  localparam logic [7:0]  SUB_STAG  = 8'h1A;
  localparam logic [7:0]  RST_ENTRIES = 8'h01;
  localparam logic [7:0]  SET_ENTRIES = 8'h1A;
  localparam logic [7:0]  TAB_ENTRIES = 8'h1A;
  localparam logic [31:0] RST_MAGIC   = 32'h64616F6C;

  // -------------------------------------------------------------
  // delivery values
  // -------------------------------------------------------------
  localparam logic [31:0] KEY_DEF   = 32'h00000000;
  localparam logic [7:0]  RATED_DEF = 8'h0A;
  localparam logic [7:0]  CURVE_DEF = 8'h01;
  localparam logic [15:0] WARN_DEF  = 16'h005A;
  localparam logic [7:0]  PRET_DEF  = 8'h02;
  localparam logic [7:0]  INFN_DEF  = 8'h02;
  localparam logic [7:0]  OVR_DEF   = 8'h01;
  localparam logic [7:0]  UVL_DEF   = 8'hAA;
  localparam logic [7:0]  RFF_DEF   = 8'h01;
  localparam logic [7:0]  LOCK_DEF  = 8'h00;
  localparam logic [15:0] STAG_DEF  = 16'h0000;

  // -------------------------------------------------------------
  // choice codes
  // -------------------------------------------------------------
  localparam logic [7:0]  PRET_OFF   = 8'h00;
  localparam logic [7:0]  PRET_ON    = 8'h01;
  localparam logic [7:0]  INFN_RESET = 8'h00;
  localparam logic [7:0]  INFN_POWER = 8'h01;
  localparam logic [7:0]  INFN_BOTH  = 8'h02;
  localparam logic [7:0]  OVR_AUTO   = 8'h01;
  localparam logic [7:0]  RFF_FAST   = 8'h00;
  localparam logic [7:0]  RFF_SLOW   = 8'h02;
  localparam logic [7:0]  LOCK_ON    = 8'h01;
  localparam logic [15:0] STAG_OFF   = 16'h0000;
  localparam logic [7:0]  UV_HYST    = 8'h0A;

endpackage : ocp_pkg

/* File: hw/ocp_rf_filt.sv */
`timescale 1ns/10ps
module ocp_rf_filt
  import ocp_pkg::*;
(
  input  wire logic             i_clk,
  input  wire logic             i_nrst,
  input  wire logic             i_cond,
  input  wire logic [CNT_W-1:0] i_limit,
  output logic                  o_trip
);

  typedef struct packed {
    logic [CNT_W-1:0] cnt;
    logic             trip;
  } ocp_rf_st_t;

  ocp_rf_st_t st_r;
  ocp_rf_st_t st_nxt;

  // -------------------------------------------------------------
  // filter counter
  // -------------------------------------------------------------
  always_comb begin
    st_nxt      = st_r;
    st_nxt.trip = 1'b0;
    if (!i_cond) begin
      st_nxt.cnt = '0;
    end else if (st_r.cnt >= i_limit) begin
      st_nxt.trip = 1'b1;
    end else begin
      st_nxt.cnt = st_r.cnt + 1'b1;
    end
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign o_trip = st_r.trip;

  a_rf_trip_time: assert property (
    @(posedge i_clk) disable iff (!i_nrst)
    i_cond && st_r.cnt >= i_limit |=> o_trip)
    else $error("reverse feed trip missing");

endmodule : ocp_rf_filt

/* File: hw/ocp_settings.sv */
`timescale 1ns/10ps
// Function
// - writing the fixed key to the restore entry reloads every backup setting.
// - each of the two channels keeps its own settings bank, index step 0x10.
// - each channel holds a writable 8-bit rated current value.
// - each channel holds a tripping curve selector, delivered as 1.
// - a channel warns once its current reaches its 16-bit warning level.
// - on supply return each output goes off, on, or keeps its last state.
// - the local input and button reset, toggle power, do both, or nothing.
// - overvoltage trips the outputs; they stay off or return automatically.
// - undervoltage is flagged below a set threshold with 1 V hysteresis.
// - reverse feed switches off after the chosen 10, 100 or 1000 ms filter.
// - the button may set the rated current only when programming is allowed.
// - with stagger on, channel 2 switches on about 50 ms after channel 1.
// - a manual curve gives a trip time in ms for each listed multiple.
module ocp_settings
  import ocp_pkg::*;
#(
  parameter int unsigned RF_FAST = RF_FAST_CYC,
  parameter int unsigned RF_STD  = RF_STD_CYC,
  parameter int unsigned RF_SLOW = RF_SLOW_CYC,
  parameter int unsigned STAG    = STAG_CYC
) (
  input  wire logic             i_clk,
  input  wire logic             i_nrst,
  input  wire logic             i_req,
  input  wire logic             i_wr,
  input  wire logic [15:0]      i_index,
  input  wire logic [7:0]       i_sub,
  input  wire logic [31:0]      i_wdata,
  output logic                  o_ack,
  output logic                  o_abort,
  output logic [31:0]           o_rdata,
  input  wire logic [1:0][15:0] i_cur,
  input  wire logic [7:0]       i_vin,
  input  wire logic             i_ovp,
  input  wire logic [1:0]       i_rev_feed,
  input  wire logic [1:0]       i_oc_trip,
  input  wire logic             i_supply_ret,
  input  wire logic [1:0]       i_local_evt,
  input  wire logic [1:0]       i_btn_prog,
  input  wire logic [7:0]       i_btn_rated,
  input  wire logic [1:0][4:0]  i_tab_pt,
  output logic [1:0]            o_out_on,
  output logic [1:0]            o_tripped,
  output logic [1:0]            o_prewarn,
  output logic [1:0]            o_undervolt,
  output logic [1:0][7:0]       o_rated,
  output logic [1:0][7:0]       o_curve_sel,
  output logic [1:0][15:0]      o_tab_ms
);

  // -------------------------------------------------------------
  // state
  // -------------------------------------------------------------
  typedef struct packed {
    logic [1:0][7:0]             rated, curve, pret, infn;
    logic [1:0][7:0]             ovr, uvl, rff, lock;
    logic [1:0][15:0]            warn, stag;
    logic [31:0]                 key;
    logic [1:0][TAB_N-1:0][15:0] mtab;
    logic [1:0]                  want, trip, ovt, prewarn;
    logic                        ovp;
    logic [CNT_W-1:0]            dly;
    logic                        ack, abort;
    logic [31:0]                 rdata;
    logic [1:0]                  out_on;
    logic [1:0][15:0]            tab_ms;
  } ocp_st_t;

  ocp_st_t    st_r;
  ocp_st_t    st_nxt;
  logic [1:0] rf_trip;
  logic [1:0] set_hit;
  logic [1:0] tab_hit;
  logic       stag_en;

  // -------------------------------------------------------------
  // functions
  // -------------------------------------------------------------
  function automatic ocp_st_t fn_restore(input ocp_st_t s);
    ocp_st_t r;
    r       = s;
    r.key   = KEY_DEF;
    r.rated = {2{RATED_DEF}};
    r.curve = {2{CURVE_DEF}};
    r.warn  = {2{WARN_DEF}};
    r.pret  = {2{PRET_DEF}};
    r.infn  = {2{INFN_DEF}};
    r.ovr   = {2{OVR_DEF}};
    r.uvl   = {2{UVL_DEF}};
    r.rff   = {2{RFF_DEF}};
    r.lock  = {2{LOCK_DEF}};
    r.stag  = {2{STAG_DEF}};
    r.mtab  = '0;
    return r;
  endfunction : fn_restore

  // hit flag, then channel number
  function automatic logic [1:0] fn_chan(input logic [15:0] idx,
                                         input logic [15:0] base);
    logic [15:0] b2;
    b2      = base + IDX_STEP;
    fn_chan = {(idx == base) || (idx == b2), idx == b2};
  endfunction : fn_chan

  function automatic logic [CNT_W-1:0] fn_rf_limit(input logic [7:0] sel);
    logic [CNT_W-1:0] lim;
    if (sel == RFF_FAST) begin
      lim = CNT_W'(RF_FAST);
    end else if (sel == RFF_SLOW) begin
      lim = CNT_W'(RF_SLOW);
    end else begin
      lim = CNT_W'(RF_STD);
    end
    return lim;
  endfunction : fn_rf_limit

  function automatic logic [31:0] fn_rd_set(input ocp_st_t s,
                                            input logic    ch,
                                            input logic [7:0] sub);
    logic [31:0] r;
    r = '0;
    case (sub)
      SUB_CNT:   r = {24'h000000, SET_ENTRIES};
      SUB_RATED: r = {24'h000000, s.rated[ch]};
      SUB_CURVE: r = {24'h000000, s.curve[ch]};
      SUB_WARN:  r = {16'h0000, s.warn[ch]};
      SUB_PRET:  r = {24'h000000, s.pret[ch]};
      SUB_INFN:  r = {24'h000000, s.infn[ch]};
      SUB_OVR:   r = {24'h000000, s.ovr[ch]};
      SUB_UVL:   r = {24'h000000, s.uvl[ch]};
      SUB_RFF:   r = {24'h000000, s.rff[ch]};
      SUB_LOCK:  r = {24'h000000, s.lock[ch]};
      SUB_STAG:  r = {16'h0000, s.stag[ch]};
      default:   r = '0;
    endcase
    return r;
  endfunction : fn_rd_set

  // -------------------------------------------------------------
  // decode
  // -------------------------------------------------------------
  assign set_hit = fn_chan(i_index, IDX_SET);
  assign tab_hit = fn_chan(i_index, IDX_TAB);
  assign stag_en = st_r.stag[1] != STAG_OFF;

  // -------------------------------------------------------------
  // next state
  // -------------------------------------------------------------
  always_comb begin
    st_nxt       = st_r;
    st_nxt.ack   = 1'b0;
    st_nxt.abort = 1'b0;
    for (int c = 0; c < 2; c++) begin
      st_nxt.prewarn[c] = i_cur[c] >= st_r.warn[c];
      if (i_btn_prog[c] && st_r.lock[c] == LOCK_ON) begin
        st_nxt.rated[c] = i_btn_rated;
      end
      if (i_supply_ret) begin
        if (st_r.pret[c] == PRET_OFF) begin
          st_nxt.want[c] = 1'b0;
        end else if (st_r.pret[c] == PRET_ON) begin
          st_nxt.want[c] = 1'b1;
        end
      end else if (i_local_evt[c]) begin
        if (st_r.trip[c]) begin
          if (st_r.infn[c] == INFN_RESET || st_r.infn[c] == INFN_BOTH) begin
            st_nxt.want[c] = 1'b1;
            st_nxt.trip[c] = 1'b0;
            st_nxt.ovt[c]  = 1'b0;
          end
        end else if (st_r.infn[c] == INFN_POWER ||
                     st_r.infn[c] == INFN_BOTH) begin
          st_nxt.want[c] = !st_r.want[c];
        end
      end
      if (!i_ovp && st_r.ovp && st_r.ovt[c] && st_r.ovr[c] == OVR_AUTO) begin
        st_nxt.want[c] = 1'b1;
        st_nxt.trip[c] = 1'b0;
        st_nxt.ovt[c]  = 1'b0;
      end
      if (i_ovp) begin
        st_nxt.want[c] = 1'b0;
        if (!st_r.ovp) begin
          st_nxt.trip[c] = 1'b1;
          st_nxt.ovt[c]  = 1'b1;
        end
      end
      if (i_oc_trip[c] || rf_trip[c]) begin
        st_nxt.want[c] = 1'b0;
        st_nxt.trip[c] = 1'b1;
      end
      if (i_tab_pt[c] <= TAB_LAST) begin
        st_nxt.tab_ms[c] = st_r.mtab[c][i_tab_pt[c]];
      end else begin
        st_nxt.tab_ms[c] = '0;
      end
    end
    st_nxt.ovp = i_ovp;

    // object access, after local sources so the bus wins
    if (i_req) begin
      st_nxt.ack   = 1'b1;
      st_nxt.rdata = '0;
      if (i_index == IDX_RST) begin
        if (i_sub == SUB_CNT && !i_wr) begin
          st_nxt.rdata = {24'h000000, RST_ENTRIES};
        end else if (i_sub == SUB_KEY && i_wr) begin
          st_nxt.key = i_wdata;
          if (i_wdata == RST_MAGIC) begin
            st_nxt = fn_restore(st_nxt);
          end
        end else if (i_sub == SUB_KEY) begin
          st_nxt.rdata = st_r.key;
        end else begin
          st_nxt.abort = 1'b1;
        end
      end else if (set_hit[1]) begin
        if (!i_wr) begin
          st_nxt.rdata = fn_rd_set(st_r, set_hit[0], i_sub);
          st_nxt.abort = i_sub != SUB_CNT &&
                         (i_sub < SUB_RATED || i_sub > SUB_STAG);
        end else begin
          case (i_sub)
            SUB_RATED: st_nxt.rated[set_hit[0]] = i_wdata[7:0];
            SUB_CURVE: st_nxt.curve[set_hit[0]] = i_wdata[7:0];
            SUB_WARN:  st_nxt.warn[set_hit[0]]  = i_wdata[15:0];
            SUB_PRET:  st_nxt.pret[set_hit[0]]  = i_wdata[7:0];
            SUB_INFN:  st_nxt.infn[set_hit[0]]  = i_wdata[7:0];
            SUB_OVR:   st_nxt.ovr[set_hit[0]]   = i_wdata[7:0];
            SUB_UVL:   st_nxt.uvl[set_hit[0]]   = i_wdata[7:0];
            SUB_RFF:   st_nxt.rff[set_hit[0]]   = i_wdata[7:0];
            SUB_LOCK:  st_nxt.lock[set_hit[0]]  = i_wdata[7:0];
            SUB_STAG:  st_nxt.stag[set_hit[0]]  = i_wdata[15:0];
            default:   st_nxt.abort = 1'b1;
          endcase
        end
      end else if (tab_hit[1]) begin
        if (i_sub == SUB_CNT && !i_wr) begin
          st_nxt.rdata = {24'h000000, TAB_ENTRIES};
        end else if (i_sub == SUB_CNT || i_sub > TAB_ENTRIES) begin
          st_nxt.abort = 1'b1;
        end else if (i_wr) begin
          st_nxt.mtab[tab_hit[0]][5'(i_sub - 8'h01)] = i_wdata[15:0];
        end else begin
          st_nxt.rdata = {16'h0000,
                          st_r.mtab[tab_hit[0]][5'(i_sub - 8'h01)]};
        end
      end else begin
        st_nxt.abort = 1'b1;
      end
    end

    // with stagger on, channel 2 switch-on held until channel 1 has run its delay
    if (!st_r.out_on[0]) begin
      st_nxt.dly = '0;
    end else if (st_r.dly < CNT_W'(STAG)) begin
      st_nxt.dly = st_r.dly + 1'b1;
    end
    st_nxt.out_on[0] = st_nxt.want[0];
    st_nxt.out_on[1] = st_nxt.want[1] && (st_r.out_on[1] || !stag_en ||
                       st_r.dly == CNT_W'(STAG));
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      st_r <= fn_restore('0);
    end else begin
      st_r <= st_nxt;
    end
  end

  // -------------------------------------------------------------
  // per-channel filters and monitors
  // -------------------------------------------------------------
  for (genvar g = 0; g < 2; g++) begin : g_ch
    ocp_rf_filt u_rf (
      .i_clk   (i_clk),
      .i_nrst  (i_nrst),
      .i_cond  (i_rev_feed[g] && st_r.want[g]),
      .i_limit (fn_rf_limit(st_r.rff[g])),
      .o_trip  (rf_trip[g])
    );
    ocp_uv_det u_uv (
      .i_clk  (i_clk),
      .i_nrst (i_nrst),
      .i_vin  (i_vin),
      .i_thr  (st_r.uvl[g]),
      .o_uv   (o_undervolt[g])
    );
  end

  // -------------------------------------------------------------
  // outputs
  // -------------------------------------------------------------
  assign o_ack       = st_r.ack;
  assign o_abort     = st_r.abort;
  assign o_rdata     = st_r.rdata;
  assign o_out_on    = st_r.out_on;
  assign o_tripped   = st_r.trip;
  assign o_prewarn   = st_r.prewarn;
  assign o_rated     = st_r.rated;
  assign o_curve_sel = st_r.curve;
  assign o_tab_ms    = st_r.tab_ms;

  // -------------------------------------------------------------
  // checks
  // -------------------------------------------------------------
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_nrst);

  sequence s_magic_wr;
    i_req && i_wr && i_index == IDX_RST && i_sub == SUB_KEY &&
    i_wdata == RST_MAGIC;
  endsequence

  sequence s_rated_wr0;
    i_req && i_wr && i_index == IDX_SET && i_sub == SUB_RATED;
  endsequence

  a_restore_all: assert property (
    s_magic_wr |=> st_r.warn == {2{WARN_DEF}} &&
    o_curve_sel == {2{CURVE_DEF}} && st_r.uvl == {2{UVL_DEF}} &&
    st_r.key == KEY_DEF && o_rated == {2{RATED_DEF}})
    else $error("restore left a setting changed");

  a_bank_apart: assert property (
    (s_rated_wr0 and !i_btn_prog[1]) |=> $stable(o_rated[1]))
    else $error("channel 1 write reached channel 2");

  a_rated_store: assert property (
    s_rated_wr0 |=> o_rated[0] == $past(i_wdata[7:0]))
    else $error("rated current not stored");

  a_curve_store: assert property (
    i_req && i_wr && i_index == 16'h8010 && i_sub == SUB_CURVE
    |=> o_curve_sel[1] == $past(i_wdata[7:0]))
    else $error("curve selector not stored");

  a_prewarn_lvl: assert property (
    i_cur[0] >= st_r.warn[0] |=> o_prewarn[0])
    else $error("prewarning missing");

  a_return_off: assert property (
    i_supply_ret && st_r.pret[0] == PRET_OFF |=> !o_out_on[0])
    else $error("output on after supply return");

  a_local_reset: assert property (
    i_local_evt[0] && !i_supply_ret && o_tripped[0] &&
    st_r.infn[0] == INFN_RESET && !i_ovp && !i_oc_trip[0] &&
    !rf_trip[0] |=> !o_tripped[0] ##1 o_out_on[0] || o_tripped[0])
    else $error("local reset ignored");

  a_ov_trip: assert property (
    i_ovp && !st_r.ovp |=> o_tripped == 2'b11 && o_out_on == 2'b00)
    else $error("overvoltage did not trip");

  a_btn_locked: assert property (
    i_btn_prog[0] && st_r.lock[0] != LOCK_ON && !i_req
    |=> $stable(o_rated[0]))
    else $error("locked button changed rated current");

  a_stagger_gap: assert property (
    $rose(o_out_on[1]) && $past(stag_en)
    |-> $past(st_r.dly) == CNT_W'(STAG))
    else $error("channel 2 switched on early");

  a_tab_lookup: assert property (
    i_tab_pt[0] <= TAB_LAST
    |=> o_tab_ms[0] == $past(st_r.mtab[0][i_tab_pt[0]]))
    else $error("manual curve lookup wrong");

endmodule : ocp_settings

/* File: hw/ocp_uv_det.sv */
`timescale 1ns/10ps
module ocp_uv_det
  import ocp_pkg::*;
(
  input  wire logic       i_clk,
  input  wire logic       i_nrst,
  input  wire logic [7:0] i_vin,
  input  wire logic [7:0] i_thr,
  output logic            o_uv
);

  typedef struct packed {
    logic uv;
  } ocp_uv_st_t;

  ocp_uv_st_t st_r;
  ocp_uv_st_t st_nxt;
  logic [8:0] rel_lvl;

  // -------------------------------------------------------------
  // threshold with hysteresis
  // -------------------------------------------------------------
  assign rel_lvl = {1'b0, i_thr} + {1'b0, UV_HYST};

  always_comb begin
    st_nxt = st_r;
    if (i_vin < i_thr) begin
      st_nxt.uv = 1'b1;
    end else if ({1'b0, i_vin} >= rel_lvl) begin
      st_nxt.uv = 1'b0;
    end
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign o_uv = st_r.uv;

  a_uv_set_hold: assert property (
    @(posedge i_clk) disable iff (!i_nrst)
    (i_vin < i_thr) || (o_uv && {1'b0, i_vin} < rel_lvl) |=> o_uv)
    else $error("undervoltage flag not held");

endmodule : ocp_uv_det

/* File: verif/ocp_master.sv */
`timescale 1ns/10ps
module ocp_master (
  input  wire logic        i_clk,
  input  wire logic        i_ack,
  input  wire logic        i_abort,
  input  wire logic [31:0] i_rdata,
  output logic             o_req,
  output logic             o_wr,
  output logic [15:0]      o_index,
  output logic [7:0]       o_sub,
  output logic [31:0]      o_wdata
);
  initial begin
    o_req = 1'b0;
    o_wr = 1'b0;
    o_index = 16'h0000;
    o_sub = 8'h00;
    o_wdata = 32'h00000000;
  end
  // ---------------------------------------------------------
  // one object access, answer taken one edge later
  // ---------------------------------------------------------
  task automatic access(input logic w, input logic [15:0] ix,
                        input logic [7:0] sb, input logic [31:0] d,
                        output logic [31:0] r, output logic ab);
    @(posedge i_clk);
    #1;
    o_req = 1'b1;
    o_wr = w;
    o_index = ix;
    o_sub = sb;
    o_wdata = d;
    @(posedge i_clk);
    #1;
    r = i_rdata;
    ab = (i_ack === 1'b1) ? i_abort : 1'bx;
    // released lines show the inverse, not the last value
    o_req = 1'b0;
    o_wr = ~w;
    o_index = ~ix;
    o_sub = ~sb;
    o_wdata = ~d;
  endtask : access
endmodule : ocp_master

/* File: verif/overcurrent_channel_settings_bench.sv */
`timescale 1ns/10ps
module overcurrent_channel_settings_bench
  import ocp_pkg::*;
;
  localparam logic [15:0] B1 = IDX_SET + IDX_STEP;
  localparam logic [15:0] T1 = IDX_TAB + IDX_STEP;
  logic clk, nrst, req, wr, ack, abort, ovp, sret;
  logic [15:0]      idx;
  logic [7:0]       sub, vin, brated;
  logic [31:0]      wdata, rdata;
  logic [1:0][15:0] cur, tabms;
  logic [1:0]       rev, levt, bprog, out_on, tripped, prewarn, uvf;
  logic [1:0][7:0]  rated, curve;
  logic [1:0][4:0]  tabpt;
  int               err_count, samples_checked;

  ocp_master i_ocp_master (.i_clk(clk), .i_ack(ack), .i_abort(abort),
    .i_rdata(rdata), .o_req(req), .o_wr(wr), .o_index(idx), .o_sub(sub),
    .o_wdata(wdata));
  ocp_settings #(.RF_FAST(10), .RF_STD(20), .RF_SLOW(40), .STAG(8))
  i_ocp_settings (.i_clk(clk), .i_nrst(nrst), .i_req(req), .i_wr(wr),
    .i_index(idx), .i_sub(sub), .i_wdata(wdata), .o_ack(ack),
    .o_abort(abort), .o_rdata(rdata), .i_cur(cur), .i_vin(vin),
    .i_ovp(ovp), .i_rev_feed(rev), .i_oc_trip(2'b00),
    .i_supply_ret(sret), .i_local_evt(levt), .i_btn_prog(bprog),
    .i_btn_rated(brated), .i_tab_pt(tabpt), .o_out_on(out_on),
    .o_tripped(tripped), .o_prewarn(prewarn), .o_undervolt(uvf),
    .o_rated(rated), .o_curve_sel(curve), .o_tab_ms(tabms));

  task automatic report_and_stop();
    $display("checked %0d errors %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : report_and_stop
  task automatic chk(input logic [31:0] g, e, input string m);
    samples_checked++;
    if (g !== e) begin
      err_count++;
      $display("[FAIL] %0t %s got %h exp %h", $time, m, g, e);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : cyc
  task automatic acc(input logic w, input logic [15:0] ix,
                     input logic [7:0] sb, input logic [31:0] d,
                     input logic ea, input logic [31:0] er);
    logic [31:0] r;
    logic        ab;
    i_ocp_master.access(w, ix, sb, d, r, ab);
    chk({31'h0, ab}, {31'h0, ea}, "abort flag");
    if (!w)
      chk(r, er, "read data");
  endtask : acc
  task automatic put(input logic [15:0] ix, input logic [7:0] sb,
                     input logic [31:0] d);
    acc(1'b1, ix, sb, d, 1'b0, 32'h0);
  endtask : put
  task automatic get(input logic [15:0] ix, input logic [7:0] sb,
                     input logic [31:0] e);
    acc(1'b0, ix, sb, 32'h0, 1'b0, e);
  endtask : get
  task automatic evt(input logic [1:0] e);
    levt = e;
    cyc(1);
    levt = 2'b00;
  endtask : evt

  // ---------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------
  task automatic t_defaults();
    logic [15:0] b;
    for (int c = 0; c < 2; c++) begin
      b = c ? B1 : IDX_SET;
      get(b, SUB_CNT, 32'h1A);
      get(b, SUB_RATED, {24'h0, RATED_DEF});
      get(b, SUB_CURVE, 32'h01);
      get(b, SUB_WARN, 32'h5A);
      get(b, SUB_PRET, 32'h02);
      get(b, SUB_INFN, 32'h02);
      get(b, SUB_OVR, 32'h01);
      get(b, SUB_UVL, 32'hAA);
      get(b, SUB_RFF, 32'h01);
      get(b, SUB_STAG, 32'h0);
    end
    get(IDX_RST, SUB_CNT, 32'h01);
    get(IDX_RST, SUB_KEY, 32'h0);
    chk({16'h0, curve}, 32'h0101, "curve outputs");
  endtask : t_defaults
  task automatic t_refuse();
    acc(1'b0, 16'h2000, 8'h01, 32'h0, 1'b1, 32'h0);
    acc(1'b1, IDX_SET, SUB_CNT, 32'h5, 1'b1, 32'h0);
    acc(1'b0, IDX_TAB, 8'h1B, 32'h0, 1'b1, 32'h0);
    get(IDX_SET, SUB_CNT, 32'h1A);
  endtask : t_refuse
  task automatic t_restore();
    put(IDX_SET, SUB_RATED, 32'h33);
    put(B1, SUB_RATED, 32'h44);
    put(IDX_SET, SUB_WARN, 32'h1234);
    put(B1, SUB_CURVE, 32'h03);
    chk({16'h0, curve}, 32'h0301, "curve write");
    chk({16'h0, rated}, 32'h4433, "rated outputs");
    put(IDX_RST, SUB_KEY, 32'h64616F6D);
    get(B1, SUB_RATED, 32'h44);
    put(IDX_RST, SUB_KEY, 32'h64616F6C);
    chk({16'h0, rated}, {16'h0, RATED_DEF, RATED_DEF}, "restore");
    chk({16'h0, curve}, 32'h0101, "curve restore");
    get(IDX_SET, SUB_WARN, 32'h5A);
    get(IDX_RST, SUB_KEY, 32'h0);
  endtask : t_restore
  task automatic t_levels();
    put(B1, SUB_WARN, 32'h0100);
    cur = {16'h0100, 16'h0059};
    cyc(2);
    chk({30'h0, prewarn}, 32'h2, "prewarn below");
    cur[0] = 16'h005A;
    cyc(2);
    chk({30'h0, prewarn}, 32'h3, "prewarn at level");
    vin = 8'hA9;
    cyc(3);
    chk({30'h0, uvf}, 32'h3, "undervolt set");
    vin = 8'hB3;
    cyc(3);
    chk({30'h0, uvf}, 32'h3, "undervolt hyst");
    vin = 8'hB4;
    cyc(3);
    chk({30'h0, uvf}, 32'h0, "undervolt clear");
  endtask : t_levels
  task automatic t_button_table();
    brated = 8'h77;
    bprog = 2'b01;
    cyc(1);
    bprog = 2'b00;
    cyc(1);
    chk({24'h0, rated[0]}, {24'h0, RATED_DEF}, "locked");
    put(IDX_SET, SUB_LOCK, 32'h01);
    bprog = 2'b01;
    cyc(1);
    bprog = 2'b00;
    cyc(1);
    chk({24'h0, rated[0]}, 32'h77, "programmed");
    put(IDX_TAB, 8'h05, 32'h1234);
    put(T1, 8'h1A, 32'hBEEF);
    tabpt = {5'h19, 5'h04};
    cyc(2);
    chk(tabms, 32'hBEEF1234, "curve table");
  endtask : t_button_table
  task automatic t_power();
    logic [7:0] fn[4] = '{8'h00, 8'h03, 8'h01, 8'h02};
    logic       fx[4] = '{1'b1, 1'b1, 1'b0, 1'b1};
    logic [7:0] pr[3] = '{8'h00, 8'h02, 8'h01};
    logic       px[3] = '{1'b0, 1'b0, 1'b1};
    evt(2'b01);
    chk({31'h0, out_on[0]}, 32'h1, "toggle on");
    for (int k = 0; k < 4; k++) begin
      put(IDX_SET, SUB_INFN, {24'h0, fn[k]});
      evt(2'b01);
      chk({31'h0, out_on[0]}, {31'h0, fx[k]}, "input fn");
    end
    for (int k = 0; k < 3; k++) begin
      put(IDX_SET, SUB_PRET, {24'h0, pr[k]});
      sret = 1'b1;
      cyc(1);
      sret = 1'b0;
      chk({31'h0, out_on[0]}, {31'h0, px[k]}, "power return");
    end
  endtask : t_power
  task automatic t_trips();
    evt(2'b10);
    put(B1, SUB_OVR, 32'h00);
    ovp = 1'b1;
    cyc(2);
    chk({30'h0, out_on}, 32'h0, "ovp off");
    ovp = 1'b0;
    cyc(2);
    chk({30'h0, out_on}, 32'h1, "ovp auto/latch");
    put(IDX_SET, SUB_RFF, 32'h00);
    rev = 2'b01;
    cyc(9);
    chk({30'h0, out_on}, 32'h1, "reverse early");
    cyc(6);
    chk({30'h0, out_on}, 32'h0, "reverse off");
    chk({30'h0, tripped}, 32'h3, "tripped");
    rev = 2'b00;
    put(IDX_SET, SUB_INFN, 32'h00);
    evt(2'b01);
    chk({30'h0, tripped}, 32'h2, "local reset");
    put(IDX_SET, SUB_INFN, 32'h01);
    evt(2'b01);
    put(B1, SUB_STAG, 32'h01);
    evt(2'b11);
    cyc(8);
    chk({30'h0, out_on}, 32'h1, "stagger wait");
    cyc(1);
    chk({30'h0, out_on}, 32'h3, "stagger on");
  endtask : t_trips

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  initial begin
    #(40 * 5000);
    err_count++;
    report_and_stop();
  end
  initial begin
    err_count = 0;
    samples_checked = 0;
    nrst = 1'b0;
    cur = '0;
    vin = 8'hFF;
    ovp = 1'b0;
    rev = 2'b00;
    sret = 1'b0;
    levt = 2'b00;
    bprog = 2'b00;
    brated = 8'h00;
    tabpt = '0;
    repeat (12) @(posedge clk);
    #1;
    nrst = 1'b1;
    t_defaults();
    t_refuse();
    t_restore();
    t_levels();
    t_button_table();
    t_power();
    t_trips();
    report_and_stop();
  end
endmodule : overcurrent_channel_settings_bench
